//--- hcfh_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module hcfh_assertions (
	// clock and reset
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	// watched ports
	input wire logic        can_mode_i,
	input wire logic        res_valid_i,
	input wire logic        tx_valid_o,
	input wire logic        tx_ready_i,
	input wire logic [7:0]  tx_data_o,
	input wire logic        tx_last_o,
	input wire logic        drv_oe_n_o,
	input wire logic        cmd_valid_o,
	input wire logic [7:0]  cmd_code_o,
	input wire logic [31:0] cmd_value_o,
	input wire logic        busy_o,
	input wire logic        sum_err_o
);
	logic [3:0] sent_ff;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// =======================================================
	// reply byte counter, restarts after the last byte
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			sent_ff <= 4'h0;
		else if (tx_valid_o && tx_ready_i)
			sent_ff <= tx_last_o ? 4'h0 : sent_ff + 4'h1;
	end
	// =======================================================
	// properties
	a_cmd_one_pulse: assert property (cmd_valid_o |=> !cmd_valid_o) else $error("cmd pulse too long");
	a_cmd_fields_hold: assert property (cmd_valid_o |=> $stable({cmd_code_o, cmd_value_o})[*4])
		else $error("cmd fields moved");
	a_tx_byte_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("reply byte dropped");
	a_reply_len: assert property (tx_valid_o && tx_ready_i && tx_last_o |-> sent_ff == (can_mode_i ? 4'h5 : 4'h8))
		else $error("reply length wrong");
	a_drv_on_tx: assert property (tx_valid_o |-> !drv_oe_n_o) else $error("driver off while sending");
	a_drv_idle_rx: assert property ((!busy_o && !tx_valid_o)[*4] |-> drv_oe_n_o) else $error("driver on idle");
	a_tx_only_reply: assert property (tx_valid_o |-> busy_o || $past(tx_valid_o)) else $error("spontaneous tx");
	a_bad_sum_no_exec: assert property ($rose(sum_err_o) |-> !cmd_valid_o[*6]) else $error("bad frame ran");
	a_result_replies: assert property (res_valid_i && busy_o |-> ##[1:4] tx_valid_o) else $error("no reply");
	// main scenarios seen
	c_reply_done: cover property (tx_valid_o && tx_ready_i && tx_last_o);
	c_stalled: cover property (tx_valid_o && !tx_ready_i);
	c_bad_sum: cover property ($rose(sum_err_o));
endmodule
bind hcfh_top hcfh_assertions chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .can_mode_i(can_mode_i),
	.res_valid_i(res_valid_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
	.tx_last_o(tx_last_o), .drv_oe_n_o(drv_oe_n_o), .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o),
	.cmd_value_o(cmd_value_o), .busy_o(busy_o), .sum_err_o(sum_err_o));
`default_nettype wire

//--- hcfh_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module hcfh_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0]  wr_ptr;
		logic [AW-1:0]  rd_ptr;
		logic [AW:0]    count;
		logic [WIDTH-1:0] dout;
		logic           dval;
	} hcfh_fifo_st_t;
	hcfh_fifo_st_t  st_ff;
	hcfh_fifo_st_t  nxt_st;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic           push;
	logic           pop;
	logic           load;
	// ===========================================================
	// handshakes; the output register counts as one slot ahead of the array
	assign in_ready_o  = (st_ff.count != (AW+1)'(DEPTH));
	assign out_valid_o = st_ff.dval;
	assign out_data_o  = st_ff.dout;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = st_ff.dval && out_ready_i;
	assign load        = (st_ff.count != '0) && (!st_ff.dval || out_ready_i);
	// next state of pointers and output register
	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.wr_ptr = st_ff.wr_ptr + AW'(1);
		end
		if (load) begin
			nxt_st.rd_ptr = st_ff.rd_ptr + AW'(1);
			nxt_st.dout   = mem_ff[st_ff.rd_ptr];
			nxt_st.dval   = 1'b1;
		end else if (pop) begin
			nxt_st.dval = 1'b0;
		end
		nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(load);
	end
	// storage array; no reset needed, read only behind count
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_ff[st_ff.wr_ptr] <= in_data_i;
		end
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule
`default_nettype wire

//--- hcfh_host.sv
`timescale 1ns/100ps
`default_nettype none
module hcfh_host (
	// clock and reset
	input wire logic       sys_clk_i,
	input wire logic       rst_i,
	// bytes toward the block
	output logic           rx_valid_o,
	output logic [7:0]     rx_data_o,
	output logic           rx_frame_start_o,
	// reply from the block
	input wire logic       tx_valid_i,
	output logic           tx_ready_o,
	input wire logic [7:0] tx_data_i,
	input wire logic       tx_last_i
);
	logic       slow = 1'b0;
	logic       done = 1'b0;
	logic [7:0] got[$];
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'hA5;
		rx_frame_start_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	// one byte per cycle; idle data flips so a stale byte never looks valid
	task automatic send(input logic [7:0] b[$]);
		done = 1'b0;
		foreach (b[i]) begin
			@(posedge sys_clk_i);
			#1;
			rx_valid_o = 1'b1;
			rx_frame_start_o = (i == 0);
			rx_data_o = b[i];
		end
		@(posedge sys_clk_i);
		#1;
		rx_valid_o = 1'b0;
		rx_frame_start_o = 1'b0;
		rx_data_o = ~rx_data_o;
	endtask
	// collect reply; slow mode stalls every other cycle
	always @(posedge sys_clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			got.push_back(tx_data_i);
			done = tx_last_i;
		end
		#1;
		tx_ready_o = !rst_i && (slow ? !tx_ready_o : 1'b1);
	end
endmodule
`default_nettype wire

//--- hcfh_pkg.sv
// What this block does
// - a command body is seven bytes: command code, type, motor or bank selector, then a four-byte value.
// - on the byte-serial link the body is framed by one leading module address byte and one trailing checksum byte, nine bytes in all.
// - the four-byte value travels most significant byte first and is assembled into a 32-bit word in that order.
// - the command checksum is the modulo-256 sum of the eight bytes before it, address included, and the device recomputes it.
// - the serial reply is reply address, module address, status, echoed command code, four value bytes, checksum.
// - the reply checksum is the modulo-256 sum of the eight reply bytes before it.
// - every command addressed to the device gets exactly one reply, sent once its processing has finished.
// - the device never transmits on its own, only in answer to a received command.
// - the line driver stays in receive direction except while a reply is being sent.
// - on the CAN-style link the frame has no address or checksum byte, the identifier is the address and no checksum check is made.
// - on the CAN-style link the reply carries no address or checksum byte, the identifier carries the reply address.
// - reply status is 100 for success and 101 when the command was stored into program memory.
// - error statuses are 1 checksum, 2 unknown command, 3 bad type, 4 bad value, 5 memory locked, 6 command unavailable.
package hcfh_pkg;
	// ===========================================================
	// frame layout
	localparam int unsigned SER_FRAME_LEN  = 9;
	localparam int unsigned CAN_FRAME_LEN  = 7;
	localparam logic [3:0]  IDX_LAST_SER   = 4'h8;
	localparam logic [3:0]  IDX_LAST_CAN   = 4'h6;
	localparam logic [3:0]  IDX_VAL_FIRST  = 4'h3;
	localparam logic [3:0]  IDX_VAL_LAST   = 4'h6;
	// ===========================================================
	// status codes
	localparam logic [7:0]  ST_OK          = 8'h64;
	localparam logic [7:0]  ST_STORED      = 8'h65;
	localparam logic [7:0]  ST_BAD_SUM     = 8'h01;
	localparam logic [7:0]  ST_BAD_CMD     = 8'h02;
	localparam logic [7:0]  ST_BAD_TYPE    = 8'h03;
	localparam logic [7:0]  ST_BAD_VALUE   = 8'h04;
	localparam logic [7:0]  ST_LOCKED      = 8'h05;
	localparam logic [7:0]  ST_UNAVAIL     = 8'h06;
	// ===========================================================
	// buffering
	localparam int unsigned FIFO_DEPTH     = 16;
	localparam int unsigned FIFO_WIDTH     = 8;
	// ===========================================================
	// control states, one-hot
	typedef enum logic [3:0] {
		HCFH_RX   = 4'h1,
		HCFH_EXEC = 4'h2,
		HCFH_WAIT = 4'h4,
		HCFH_TX   = 4'h8
	} hcfh_state_t;
endpackage

//--- hcfh_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module hcfh_tb_top;
	import hcfh_pkg::*;
	logic        clk, rst, can, rxv, rxs, txv, txr, txl, oen, cv, rv, busy, serr;
	logic [7:0]  rxd, txd, cc, ct, cb, rs;
	logic [7:0]  maddr = 8'h2A;
	logic [7:0]  raddr = 8'h02;
	logic [31:0] cval, rval;
	logic [7:0]  codes[8] = '{ST_OK, ST_STORED, ST_BAD_SUM, ST_BAD_CMD, ST_BAD_TYPE, ST_BAD_VALUE, ST_LOCKED, ST_UNAVAIL};
	int          failures = 0;
	int          cmp_count = 0;
	hcfh_top dut_u (.sys_clk_i(clk), .rst_i(rst), .can_mode_i(can), .module_addr_i(maddr), .reply_addr_i(raddr),
		.rx_valid_i(rxv), .rx_data_i(rxd), .rx_frame_start_i(rxs), .tx_valid_o(txv), .tx_ready_i(txr),
		.tx_data_o(txd), .tx_last_o(txl), .drv_oe_n_o(oen), .cmd_valid_o(cv), .cmd_code_o(cc), .cmd_type_o(ct),
		.cmd_bank_o(cb), .cmd_value_o(cval), .res_valid_i(rv), .res_status_i(rs), .res_value_i(rval),
		.busy_o(busy), .sum_err_o(serr));
	hcfh_host host_u (.sys_clk_i(clk), .rst_i(rst), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_frame_start_o(rxs),
		.tx_valid_i(txv), .tx_ready_o(txr), .tx_data_i(txd), .tx_last_i(txl));
	// =======================================================
	// shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] sum8(input logic [7:0] q[$]);
		sum8 = 8'h00;
		foreach (q[i]) sum8 += q[i];
	endfunction
	// one full exchange: frame out, optional execution, reply judged byte by byte
	task automatic xfer(input logic [7:0] a, c, t, b, input logic [31:0] v, input logic [7:0] bad, st,
		input logic [31:0] r, input logic ex_cmd, ex_rep);
		logic       seen;
		logic [7:0] f[$];
		logic [7:0] e[$];
		f = {a, c, t, b, v[31:24], v[23:16], v[15:8], v[7:0]};
		f.push_back(sum8(f) + bad);
		if (can) f = f[1:7];
		host_u.got.delete();
		host_u.send(f);
		seen = 1'b0;
		for (int i = 0; i < 30 && seen !== 1'b1; i++) begin
			@(posedge clk);
			#2;
			seen = cv;
		end
		chk(seen, ex_cmd);
		if (seen === 1'b1) begin
			chk(busy, 1'b1);
			chk({cc, ct, cb}, {c, t, b});
			chk(cval, v);
			@(posedge clk);
			#1;
			{rv, rs, rval} = {1'b1, st, r};
			@(posedge clk);
			#1;
			rv = 1'b0;
		end
		for (int i = 0; i < 300 && !host_u.done; i++) @(posedge clk);
		e = {raddr, maddr, st, c, r[31:24], r[23:16], r[15:8], r[7:0]};
		e.push_back(sum8(e));
		if (can) e = e[2:7];
		if (!ex_rep) e.delete();
		chk(host_u.got.size(), e.size());
		foreach (e[i]) chk(host_u.got[i], e[i]);
		repeat (4) @(posedge clk);
		#2;
		chk(oen, 1'b1);
	endtask
	// =======================================================
	// scenarios
	task automatic t_status;
		foreach (codes[i]) begin
			host_u.slow = i[0];
			xfer(maddr, 8'h05 + i, 8'hC3, i, 32'h80FF017E + i, 8'h00, codes[i], 32'hF1E2D3C4 - i, 1, 1);
		end
		$display("test status done");
	endtask
	task automatic t_bad_sum;
		xfer(maddr, 8'h06, 8'h01, 8'h00, 32'h12345678, 8'h01, ST_BAD_SUM, 32'h00000000, 0, 1);
		chk(serr, 1'b1);
		$display("test bad_sum done");
	endtask
	task automatic t_other_addr;
		xfer(maddr + 8'h01, 8'h01, 8'h00, 8'h00, 32'h00000010, 8'h00, ST_OK, 32'h00000000, 0, 0);
		$display("test other_addr done");
	endtask
	task automatic t_can;
		can = 1'b1;
		xfer(8'h77, 8'h0A, 8'h02, 8'h01, 32'hDEADBEEF, 8'h00, ST_OK, 32'h0102A0FF, 1, 1);
		chk(serr, 1'b0);
		can = 1'b0;
		$display("test can done");
	endtask
	// reset in mid-run: idle outputs right after release, then one normal exchange
	task automatic t_reset;
		@(posedge clk);
		#1;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		@(posedge clk);
		#2;
		chk({busy, txv, cv, serr}, 4'h0);
		chk(oen, 1'b1);
		xfer(maddr, 8'h0F, 8'h00, 8'h00, 32'h00000001, 8'h00, ST_OK, 32'h000000AA, 1, 1);
		$display("test reset done");
	endtask
	// =======================================================
	// verdict, reached from the main sequence or the watchdog
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// a dozen exchanges of under 400 cycles each fit well inside this span
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		summarize();
	end
	initial begin
		{rst, can, rv, rs, rval} = {1'b1, 1'b0, 1'b0, 8'h00, 32'h00000000};
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		t_status();
		t_bad_sum();
		t_other_addr();
		t_can();
		t_reset();
		summarize();
	end
endmodule
`default_nettype wire

//--- hcfh_top.sv
`timescale 1ns/100ps
`default_nettype none
module hcfh_top (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// configuration
	input  wire logic        can_mode_i,
	input  wire logic [7:0]  module_addr_i,
	input  wire logic [7:0]  reply_addr_i,
	// received link bytes
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_frame_start_i,
	// transmitted link bytes
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i,
	output logic [7:0]       tx_data_o,
	output logic             tx_last_o,
	output logic             drv_oe_n_o,
	// command to execution logic
	output logic             cmd_valid_o,
	output logic [7:0]       cmd_code_o,
	output logic [7:0]       cmd_type_o,
	output logic [7:0]       cmd_bank_o,
	output logic [31:0]      cmd_value_o,
	// result from execution logic
	input  wire logic        res_valid_i,
	input  wire logic [7:0]  res_status_i,
	input  wire logic [31:0] res_value_i,
	// status
	output logic             busy_o,
	output logic             sum_err_o
);
	import hcfh_pkg::*;
	typedef struct packed {
		hcfh_state_t state;
		logic [3:0]  idx;
		logic [7:0]  sum;
		logic [7:0]  addr;
		logic [7:0]  code;
		logic [7:0]  ctype;
		logic [7:0]  bank;
		logic [31:0] value;
		logic        cmd_pulse;
		logic        sum_err;
		logic [7:0]  status;
		logic [31:0] rvalue;
		logic [3:0]  tidx;
		logic [7:0]  tsum;
		logic        can_lat;
		logic [4:0]  pend;
	} hcfh_st_t;
	hcfh_st_t    st_ff;
	hcfh_st_t    nxt_st;
	logic        f_in_valid;
	logic        f_in_ready;
	logic [7:0]  f_in_data;
	logic        f_out_valid;
	logic [7:0]  f_out_data;
	logic [3:0]  last_idx;
	logic [3:0]  tx_last_idx;
	logic        fifo_cnt_one;
	logic        rx_take;

	// ===========================================================
	// reply byte selection by position
	function automatic logic [7:0] reply_byte(input hcfh_st_t s, input logic [3:0] pos, input logic [7:0] maddr,
			input logic [7:0] raddr);
		logic [7:0] b;
		b = 8'h00;
		if (s.can_lat) begin
			case (pos)
				4'h0: b = s.status;
				4'h1: b = s.code;
				4'h2: b = s.rvalue[31:24];
				4'h3: b = s.rvalue[23:16];
				4'h4: b = s.rvalue[15:8];
				4'h5: b = s.rvalue[7:0];
				default: b = 8'h00;
			endcase
		end else begin
			case (pos)
				4'h0: b = raddr;
				4'h1: b = maddr;
				4'h2: b = s.status;
				4'h3: b = s.code;
				4'h4: b = s.rvalue[31:24];
				4'h5: b = s.rvalue[23:16];
				4'h6: b = s.rvalue[15:8];
				4'h7: b = s.rvalue[7:0];
				4'h8: b = s.tsum;
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction

	// ===========================================================
	// receive path: bytes are taken only in HCFH_RX, so never while a command waits or its reply is built
	assign last_idx    = st_ff.can_lat ? IDX_LAST_CAN : IDX_LAST_SER;
	assign rx_take     = rx_valid_i && (st_ff.state == HCFH_RX);
	assign tx_last_idx = st_ff.can_lat ? (IDX_LAST_CAN - 4'h1) : IDX_LAST_SER;

	// ===========================================================
	// reply bytes enter the fifo, the link drains it
	assign f_in_data  = reply_byte(st_ff, st_ff.tidx, module_addr_i, reply_addr_i);
	assign f_in_valid = (st_ff.state == HCFH_TX) && (st_ff.tidx <= tx_last_idx);
	assign tx_valid_o = f_out_valid;
	assign tx_data_o  = f_out_data;
	// driver turns only while reply bytes are pending; fifo is fed nowhere else
	assign drv_oe_n_o = !((st_ff.state == HCFH_TX) || f_out_valid);
	assign tx_last_o  = f_out_valid && (st_ff.state != HCFH_TX) && fifo_cnt_one;
	// last reply byte on the link: only one byte still pending once the build is over
	assign fifo_cnt_one = (st_ff.pend == 5'h01);

	// ===========================================================
	// command outputs
	assign cmd_valid_o = st_ff.cmd_pulse;
	assign cmd_code_o  = st_ff.code;
	assign cmd_type_o  = st_ff.ctype;
	assign cmd_bank_o  = st_ff.bank;
	assign cmd_value_o = st_ff.value;
	assign busy_o      = (st_ff.state != HCFH_RX);
	assign sum_err_o   = st_ff.sum_err;

	// ===========================================================
	// frame assembly, checks, execution hand-off and reply build
	always_comb begin
		logic [3:0] body;
		body = 4'h0;
		nxt_st = st_ff;
		nxt_st.cmd_pulse = 1'b0;
		// pending byte count, pushed into the buffer minus taken by the link
		nxt_st.pend = st_ff.pend + 5'(f_in_valid && f_in_ready) - 5'(f_out_valid && tx_ready_i);
		case (st_ff.state)
			HCFH_RX: begin
				if (rx_frame_start_i && !rx_valid_i) begin
					nxt_st.idx = 4'h0;
					nxt_st.sum = 8'h00;
				end
				if (st_ff.idx == 4'h0) begin
					nxt_st.can_lat = can_mode_i;
				end
				if (rx_take) begin
					// body position: serial frames start with the address byte
					body = st_ff.can_lat ? st_ff.idx : (st_ff.idx - 4'h1);
					if (rx_frame_start_i) begin
						body = can_mode_i ? 4'h0 : 4'hF;
						nxt_st.can_lat = can_mode_i;
						nxt_st.sum = rx_data_i;
						nxt_st.idx = 4'h1;
					end else begin
						nxt_st.sum = st_ff.sum + rx_data_i;
						nxt_st.idx = st_ff.idx + 4'h1;
					end
					if (!nxt_st.can_lat && (body == 4'hF)) begin
						nxt_st.addr = rx_data_i;
					end
					case (body)
						4'h0: nxt_st.code  = rx_data_i;
						4'h1: nxt_st.ctype = rx_data_i;
						4'h2: nxt_st.bank  = rx_data_i;
						4'h3: nxt_st.value = {rx_data_i, st_ff.value[23:0]};
						4'h4: nxt_st.value = {st_ff.value[31:24], rx_data_i, st_ff.value[15:0]};
						4'h5: nxt_st.value = {st_ff.value[31:16], rx_data_i, st_ff.value[7:0]};
						4'h6: nxt_st.value = {st_ff.value[31:8], rx_data_i};
						default: nxt_st.value = nxt_st.value;
					endcase
					if (!rx_frame_start_i && (st_ff.idx == last_idx)) begin
						nxt_st.idx = 4'h0;
						nxt_st.sum = 8'h00;
						if (st_ff.can_lat) begin
							nxt_st.state = HCFH_EXEC;
						end else if (st_ff.addr != module_addr_i) begin
							nxt_st.state = HCFH_RX;
						end else if (st_ff.sum != rx_data_i) begin
							nxt_st.sum_err = 1'b1;
							nxt_st.status  = ST_BAD_SUM;
							nxt_st.rvalue  = 32'h0000_0000;
							nxt_st.tidx    = 4'h0;
							nxt_st.tsum    = 8'h00;
							nxt_st.state   = HCFH_TX;
						end else begin
							nxt_st.state = HCFH_EXEC;
						end
					end
				end
			end
			HCFH_EXEC: begin
				nxt_st.sum_err   = 1'b0;
				nxt_st.cmd_pulse = 1'b1;
				nxt_st.state     = HCFH_WAIT;
			end
			HCFH_WAIT: begin
				if (res_valid_i) begin
					nxt_st.status = res_status_i;
					nxt_st.rvalue = res_value_i;
					nxt_st.tidx   = 4'h0;
					nxt_st.tsum   = 8'h00;
					nxt_st.state  = HCFH_TX;
				end
			end
			HCFH_TX: begin
				if (f_in_valid && f_in_ready) begin
					nxt_st.tsum = st_ff.tsum + f_in_data;
					nxt_st.tidx = st_ff.tidx + 4'h1;
					if (st_ff.tidx == tx_last_idx) begin
						nxt_st.state = HCFH_RX;
					end
				end
			end
			default: nxt_st.state = HCFH_RX;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff       <= '0;
			st_ff.state <= HCFH_RX;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ===========================================================
	// reply buffer; the link can stall it, which stalls the reply build
	hcfh_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (f_in_valid),
		.in_ready_o  (f_in_ready),
		.in_data_i   (f_in_data),
		.out_valid_o (f_out_valid),
		.out_ready_i (tx_ready_i),
		.out_data_o  (f_out_data)
	);
endmodule
`default_nettype wire
